/* File: core/ccp_cfg.svh */
`ifndef CCP_CFG_SVH
`define CCP_CFG_SVH

// register byte offsets
`define CCP_OFF_CTRL 8'h00
`define CCP_OFF_CAP_LO 8'h04
`define CCP_OFF_CAP_HI 8'h08
`define CCP_OFF_STATUS 8'h0c
`define CCP_OFF_T1_CNT 8'h10
`define CCP_OFF_T1_CTL 8'h14
`define CCP_OFF_T2_CNT 8'h18
`define CCP_OFF_PERIOD 8'h1c
`define CCP_OFF_T2_CTL 8'h20
`define CCP_OFF_PIN 8'h24

// field positions
`define CCP_BYTE 7:0
`define CCP_HALF 15:0
`define CCP_CTRL_BITS 5:0
`define CCP_CTRL_MODE 3:0
`define CCP_CTRL_DLSB 5:4
`define CCP_ST_FLAG 0
`define CCP_ST_T1OV 1
`define CCP_TC_ON 0
`define CCP_TC_PS 2:1
`define CCP_PIN_DIR 0
`define CCP_PIN_DATA 1
`define CCP_PIN_LVL 2

// mode field codes
`define CCP_M_OFF 4'h0
`define CCP_M_CMP_TOG 4'h2
`define CCP_M_CAP_FALL 4'h4
`define CCP_M_CAP_RISE 4'h5
`define CCP_M_CAP_4TH 4'h6
`define CCP_M_CAP_16TH 4'h7
`define CCP_M_CMP_SET 4'h8
`define CCP_M_CMP_CLR 4'h9
`define CCP_M_CMP_SWI 4'ha
`define CCP_M_CMP_SPEC 4'hb
`define CCP_M_PWM_GRP 2'h3

// capture prescaler terminal counts
`define CCP_CAP4_LAST 2'h3
`define CCP_CAP16_LAST 4'hf

// first timer prescale terminal counts (1, 2, 4, 8)
`define CCP_T1_LIM1 3'h0
`define CCP_T1_LIM2 3'h1
`define CCP_T1_LIM4 3'h3
`define CCP_T1_LIM8 3'h7
`define CCP_T1_MAX 16'hffff

// second timer: 4 clocks per step times prescale 1, 4, 16
`define CCP_T2_PS1 2'h0
`define CCP_T2_PS4 2'h1
`define CCP_T2_LIM1 6'h03
`define CCP_T2_LIM4 6'h0f
`define CCP_T2_LIM16 6'h3f

`define CCP_DIR_RST 1'b1
`define CCP_RESP_OKAY 2'h0
`define CCP_RESP_SLVERR 2'h2

`endif

/* File: core/ccp_pkg.sv */
package ccp_pkg;

   typedef enum {
      ccp_r_ctrl, ccp_r_cap_lo, ccp_r_cap_hi, ccp_r_status, ccp_r_t1_cnt,
      ccp_r_t1_ctl, ccp_r_t2_cnt, ccp_r_period, ccp_r_t2_ctl, ccp_r_pin, ccp_r_none
   } ccp_reg_t;

   typedef struct packed {
      logic [5:0] pre;
      logic [7:0] cnt;
   } ccp_t2_st_t;

   typedef struct packed {
      logic aw_have;
      logic [7:0] aw_addr;
      logic w_have;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic [5:0] ctrl;
      logic [7:0] lo;
      logic [7:0] hi;
      logic flag;
      logic t1ov;
      logic [15:0] t1;
      logic t1_on;
      logic [1:0] t1_ps;
      logic [2:0] t1_pre;
      logic [7:0] period;
      logic t2_on;
      logic [1:0] t2_ps;
      logic dir;
      logic port_data;
      logic sync1;
      logic sync2;
      logic lvl_prev;
      logic [3:0] cap_cnt;
      logic cmp_latch;
      logic [1:0] duty_lsb;
      logic pwm_lvl;
      logic trig;
      logic conv;
      logic pin_out;
      logic pin_oe;
   } ccp_st_t;

endpackage : ccp_pkg

/* File: core/ccp_second_timer_count.sv */
`timescale 1ns/10ps
`include "ccp_cfg.svh"
module ccp_second_timer_count
   import ccp_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic on,
   input wire logic [1:0] ps,
   input wire logic [7:0] period,
   output logic [7:0] count,
   output logic [9:0] tbase_nxt,
   output logic period_end
);

   ccp_t2_st_t q;
   ccp_t2_st_t d;
   logic [5:0] lim;
   logic tick;

   always_comb begin
      d = q;
      unique case (ps)
         `CCP_T2_PS1: lim = `CCP_T2_LIM1;
         `CCP_T2_PS4: lim = `CCP_T2_LIM4;
         default: lim = `CCP_T2_LIM16;
      endcase
      tick = on && (q.pre == lim);
      period_end = tick && (q.cnt == period);
      // off holds the count where it stands
      if (on) begin
         d.pre = tick ? '0 : q.pre + 6'h01;
      end
      if (tick) begin
         d.cnt = period_end ? '0 : q.cnt + 8'h01;
      end
      // two low time-base bits follow the prescale in use
      unique case (ps)
         `CCP_T2_PS1: tbase_nxt = {d.cnt, d.pre[1:0]};
         `CCP_T2_PS4: tbase_nxt = {d.cnt, d.pre[3:2]};
         default: tbase_nxt = {d.cnt, d.pre[5:4]};
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign count = q.cnt;

endmodule : ccp_second_timer_count

/* File: core/ccp_unit.sv */
// Implementation choices: the AXI4-Lite register port and the address map.
`timescale 1ns/10ps
`include "ccp_cfg.svh"
// Overview of operation
// - capture event copies 16-bit first timer
// - mode picks falling, rising, 4th, 16th
// - captures set sticky flag; software clears
// - newer capture overwrites unread older value
// - own driven pin level feeds detector
// - prescaler cleared when off, non-capture, reset
// - capture-to-capture switch keeps prescaler count
// - compare every cycle; act and flag
// - clearing control forces compare latch low
// - code 1010 flags only, pin untouched
// - code 1011 resets timer, starts conversion
// - trigger with match; reset next tick
// - trigger reset never sets overflow flag
// - match removed before tick cancels reset
// - clearing control releases pin from pwm
// - period is (period+1)*4*prescale clocks
// - after period match clear, load, set
// - duty is low register plus control bits
// - high register read-only, shows duty used
// - pulse high duty times prescale clocks
// - pin low when time base equals duty
// - duty beyond period leaves pin unchanged
module ccp_unit
   import ccp_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic pin_in,
   output logic pin_out,
   output logic pin_oe,
   input wire logic adc_enable,
   output logic special_trigger,
   output logic conv_start,
   output logic unit_request_flag
);

   localparam ccp_st_t ST_RST = '{dir: `CCP_DIR_RST, default: '0};

   ccp_st_t q;
   ccp_st_t d;
   logic [7:0] t2_cnt;
   logic [9:0] t2_tbase_nxt;
   logic t2_end;

   function automatic ccp_reg_t dec(input logic [7:0] a);
      ccp_reg_t r;
      unique case ({a[7:2], 2'b00})
         `CCP_OFF_CTRL: r = ccp_r_ctrl;
         `CCP_OFF_CAP_LO: r = ccp_r_cap_lo;
         `CCP_OFF_CAP_HI: r = ccp_r_cap_hi;
         `CCP_OFF_STATUS: r = ccp_r_status;
         `CCP_OFF_T1_CNT: r = ccp_r_t1_cnt;
         `CCP_OFF_T1_CTL: r = ccp_r_t1_ctl;
         `CCP_OFF_T2_CNT: r = ccp_r_t2_cnt;
         `CCP_OFF_PERIOD: r = ccp_r_period;
         `CCP_OFF_T2_CTL: r = ccp_r_t2_ctl;
         `CCP_OFF_PIN: r = ccp_r_pin;
         default: r = ccp_r_none;
      endcase
      return r;
   endfunction : dec

   function automatic logic [31:0] rd_word(input ccp_st_t s, input ccp_reg_t r, input logic [7:0] t2c);
      logic [31:0] v;
      v = '0;
      unique case (r)
         ccp_r_ctrl: v[`CCP_CTRL_BITS] = s.ctrl;
         ccp_r_cap_lo: v[`CCP_BYTE] = s.lo;
         ccp_r_cap_hi: v[`CCP_BYTE] = s.hi;
         ccp_r_status: begin
            v[`CCP_ST_FLAG] = s.flag;
            v[`CCP_ST_T1OV] = s.t1ov;
         end
         ccp_r_t1_cnt: v[`CCP_HALF] = s.t1;
         ccp_r_t1_ctl: begin
            v[`CCP_TC_ON] = s.t1_on;
            v[`CCP_TC_PS] = s.t1_ps;
         end
         ccp_r_t2_cnt: v[`CCP_BYTE] = t2c;
         ccp_r_period: v[`CCP_BYTE] = s.period;
         ccp_r_t2_ctl: begin
            v[`CCP_TC_ON] = s.t2_on;
            v[`CCP_TC_PS] = s.t2_ps;
         end
         ccp_r_pin: begin
            v[`CCP_PIN_DIR] = s.dir;
            v[`CCP_PIN_DATA] = s.port_data;
            v[`CCP_PIN_LVL] = s.sync2;
         end
         ccp_r_none: v = '0;
      endcase
      return v;
   endfunction : rd_word

   function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
      logic [31:0] r;
      r = o;
      for (int i = 0; i < 4; i++) begin
         if (s[i]) begin
            r[i*8 +: 8] = n[i*8 +: 8];
         end
      end
      return r;
   endfunction : merge

   function automatic logic is_cap(input logic [3:0] m);
      return m inside {`CCP_M_CAP_FALL, `CCP_M_CAP_RISE, `CCP_M_CAP_4TH, `CCP_M_CAP_16TH};
   endfunction : is_cap

   function automatic logic is_cmp(input logic [3:0] m);
      return m inside {`CCP_M_CMP_TOG, `CCP_M_CMP_SET, `CCP_M_CMP_CLR, `CCP_M_CMP_SWI, `CCP_M_CMP_SPEC};
   endfunction : is_cmp

   // only these three compare codes own the pin
   function automatic logic cmp_drives(input logic [3:0] m);
      return m inside {`CCP_M_CMP_TOG, `CCP_M_CMP_SET, `CCP_M_CMP_CLR};
   endfunction : cmp_drives

   function automatic logic is_pwm(input logic [3:0] m);
      return m[3:2] == `CCP_M_PWM_GRP;
   endfunction : is_pwm

   function automatic logic [2:0] t1_lim(input logic [1:0] ps);
      logic [2:0] l;
      unique case (ps)
         2'h0: l = `CCP_T1_LIM1;
         2'h1: l = `CCP_T1_LIM2;
         2'h2: l = `CCP_T1_LIM4;
         2'h3: l = `CCP_T1_LIM8;
      endcase
      return l;
   endfunction : t1_lim

   ccp_second_timer_count u_second_timer_count (
      .aclk(aclk),
      .aresetn(aresetn),
      .on(q.t2_on),
      .ps(q.t2_ps),
      .period(q.period),
      .count(t2_cnt),
      .tbase_nxt(t2_tbase_nxt),
      .period_end(t2_end)
   );

   always_comb begin
      logic [3:0] mode;
      logic [3:0] mode_nxt;
      ccp_reg_t wsel;
      logic [31:0] wv;
      logic [31:0] wclr;
      logic do_wr;
      logic t1_tick;
      logic t1_ovf;
      logic match_cur;
      logic match_nxt;
      logic enter;
      logic lvl;
      logic rise;
      logic fall;
      logic cap_ev;
      logic [9:0] duty_new;
      mode = q.ctrl[`CCP_CTRL_MODE];
      mode_nxt = '0;
      wsel = dec(q.aw_addr);
      wv = merge(rd_word(q, wsel, t2_cnt), q.w_data, q.w_strb);
      wclr = merge('0, q.w_data, q.w_strb);
      do_wr = q.aw_have && q.w_have && !q.bvalid;
      t1_tick = q.t1_on && (q.t1_pre == t1_lim(q.t1_ps));
      t1_ovf = 1'b0;
      match_cur = q.t1 == {q.hi, q.lo};
      match_nxt = 1'b0;
      enter = 1'b0;
      lvl = 1'b0;
      rise = 1'b0;
      fall = 1'b0;
      cap_ev = 1'b0;
      duty_new = {q.lo, q.ctrl[`CCP_CTRL_DLSB]};
      d = q;

      // pin synchroniser, first stage read only by the second
      d.sync1 = pin_in;
      d.sync2 = q.sync1;

      // write channel: address and data may arrive in either order
      if (q.awready && awvalid) begin
         d.aw_have = 1'b1;
         d.aw_addr = awaddr;
      end
      if (q.wready && wvalid) begin
         d.w_have = 1'b1;
         d.w_data = wdata;
         d.w_strb = wstrb;
      end
      if (q.bvalid && bready) begin
         d.bvalid = 1'b0;
      end

      // first timer; its own update goes before software writes so a write wins
      if (!q.t1_on) begin
         d.t1_pre = '0;
      end else if (t1_tick) begin
         d.t1_pre = '0;
      end else begin
         d.t1_pre = q.t1_pre + 3'h1;
      end
      if (t1_tick) begin
         if (mode == `CCP_M_CMP_SPEC && match_cur) begin
            d.t1 = '0;
         end else begin
            d.t1 = q.t1 + 16'h0001;
            if (q.t1 == `CCP_T1_MAX) begin
               t1_ovf = 1'b1;
            end
         end
      end

      if (do_wr) begin
         d.aw_have = 1'b0;
         d.w_have = 1'b0;
         d.bvalid = 1'b1;
         d.bresp = (wsel == ccp_r_none) ? `CCP_RESP_SLVERR : `CCP_RESP_OKAY;
         unique case (wsel)
            ccp_r_ctrl: d.ctrl = wv[`CCP_CTRL_BITS];
            ccp_r_cap_lo: d.lo = wv[`CCP_BYTE];
            ccp_r_cap_hi: begin
               if (!is_pwm(mode)) begin
                  d.hi = wv[`CCP_BYTE];
               end
            end
            ccp_r_status: begin
               // write one to clear; a hardware set below still wins
               if (wclr[`CCP_ST_FLAG]) begin
                  d.flag = 1'b0;
               end
               if (wclr[`CCP_ST_T1OV]) begin
                  d.t1ov = 1'b0;
               end
            end
            ccp_r_t1_cnt: d.t1 = wv[`CCP_HALF];
            ccp_r_t1_ctl: begin
               d.t1_on = wv[`CCP_TC_ON];
               d.t1_ps = wv[`CCP_TC_PS];
            end
            ccp_r_period: d.period = wv[`CCP_BYTE];
            ccp_r_t2_ctl: begin
               d.t2_on = wv[`CCP_TC_ON];
               d.t2_ps = wv[`CCP_TC_PS];
            end
            ccp_r_pin: begin
               d.dir = wv[`CCP_PIN_DIR];
               d.port_data = wv[`CCP_PIN_DATA];
            end
            ccp_r_t2_cnt, ccp_r_none: d.bresp = d.bresp;
         endcase
      end
      // overflow in the cycle of its clear still sets the flag
      if (t1_ovf) begin
         d.t1ov = 1'b1;
      end
      mode_nxt = d.ctrl[`CCP_CTRL_MODE];

      // an output pin is observed through its own drive
      lvl = q.dir ? q.sync2 : q.pin_out;
      rise = lvl && !q.lvl_prev;
      fall = !lvl && q.lvl_prev;
      d.lvl_prev = lvl;

      // switching between capture codes keeps the count, so a stray event can follow
      if (!is_cap(mode)) begin
         d.cap_cnt = '0;
      end else if (rise) begin
         d.cap_cnt = q.cap_cnt + 4'h1;
      end
      unique case (mode)
         `CCP_M_CAP_FALL: cap_ev = fall;
         `CCP_M_CAP_RISE: cap_ev = rise;
         `CCP_M_CAP_4TH: cap_ev = rise && (q.cap_cnt[1:0] == `CCP_CAP4_LAST);
         `CCP_M_CAP_16TH: cap_ev = rise && (q.cap_cnt == `CCP_CAP16_LAST);
         default: cap_ev = 1'b0;
      endcase
      if (cap_ev) begin
         // capture wins over a software write in the same cycle
         d.lo = q.t1[7:0];
         d.hi = q.t1[15:8];
         d.flag = 1'b1;
      end

      // compare acts once, on entry into the match
      match_nxt = d.t1 == {d.hi, d.lo};
      enter = match_nxt && !match_cur;
      d.trig = 1'b0;
      if (is_cmp(mode) && enter) begin
         d.flag = 1'b1;
         unique case (mode)
            `CCP_M_CMP_TOG: d.cmp_latch = !q.cmp_latch;
            `CCP_M_CMP_SET: d.cmp_latch = 1'b1;
            `CCP_M_CMP_CLR: d.cmp_latch = 1'b0;
            `CCP_M_CMP_SPEC: d.trig = 1'b1;
            default: d.cmp_latch = q.cmp_latch;
         endcase
      end
      d.conv = d.trig && adc_enable;
      if (mode_nxt == `CCP_M_OFF) begin
         d.cmp_latch = 1'b0;
      end

      // pwm: period end reloads duty, time-base match ends the pulse
      if (!is_pwm(mode)) begin
         d.pwm_lvl = 1'b0;
      end else if (t2_end) begin
         d.hi = duty_new[9:2];
         d.duty_lsb = duty_new[1:0];
         d.pwm_lvl = duty_new != '0;
      end else if (t2_tbase_nxt == {q.hi, q.duty_lsb}) begin
         d.pwm_lvl = 1'b0;
      end

      // pin mux; off or a non-driving code hands the pin back to the port latch
      if (is_pwm(mode_nxt)) begin
         d.pin_out = d.pwm_lvl;
      end else if (cmp_drives(mode_nxt)) begin
         d.pin_out = d.cmp_latch;
      end else begin
         d.pin_out = d.port_data;
      end
      d.pin_oe = !d.dir;

      // read channel
      if (q.rvalid && rready) begin
         d.rvalid = 1'b0;
      end
      if (q.arready && arvalid) begin
         d.rvalid = 1'b1;
         d.rdata = rd_word(q, dec(araddr), t2_cnt);
         d.rresp = (dec(araddr) == ccp_r_none) ? `CCP_RESP_SLVERR : `CCP_RESP_OKAY;
      end
      d.arready = !d.rvalid;
      d.awready = !d.aw_have;
      d.wready = !d.w_have;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= ST_RST;
      end else begin
         q <= d;
      end
   end

   assign awready = q.awready;
   assign wready = q.wready;
   assign bvalid = q.bvalid;
   assign bresp = q.bresp;
   assign arready = q.arready;
   assign rvalid = q.rvalid;
   assign rdata = q.rdata;
   assign rresp = q.rresp;
   assign pin_out = q.pin_out;
   assign pin_oe = q.pin_oe;
   assign special_trigger = q.trig;
   assign conv_start = q.conv;
   assign unit_request_flag = q.flag;

endmodule : ccp_unit

/* File: verif/ccp_unit_checker.sv */
`timescale 1ns/10ps
module ccp_unit_checker (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic wready,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic rvalid,
   input wire logic rready,
   input wire logic pin_oe,
   input wire logic adc_enable,
   input wire logic special_trigger,
   input wire logic conv_start,
   input wire logic unit_request_flag
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   a_trig_pulse: assert property (special_trigger |=> !special_trigger)
      else $error("special trigger wider than one cycle");
   a_conv_gate: assert property (special_trigger |-> conv_start == $past(adc_enable))
      else $error("conversion start ignores converter enable");
   a_conv_cause: assert property (conv_start |-> special_trigger)
      else $error("conversion start without trigger");
   a_trig_flag: assert property (special_trigger |-> ##[0:1] unit_request_flag)
      else $error("trigger without request flag");
   a_flag_sticky: assert property ($fell(unit_request_flag) |-> !$past(wready) || !$past(wready, 2))
      else $error("request flag dropped without a write");
   a_oe_by_write: assert property ($changed(pin_oe) |-> !$past(wready) || !$past(wready, 2))
      else $error("pin drive changed without a write");
   a_b_hold: assert property (bvalid && !bready |=> bvalid)
      else $error("write response withdrawn");
   a_r_hold: assert property (rvalid && !rready |=> rvalid)
      else $error("read response withdrawn");
   a_r_answer: assert property (arvalid && arready |=> rvalid && !arready)
      else $error("read answer not in next cycle");
endmodule : ccp_unit_checker

bind ccp_unit ccp_unit_checker chk_u (.aclk(aclk), .aresetn(aresetn), .wready(wready), .bvalid(bvalid),
   .bready(bready), .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready), .pin_oe(pin_oe),
   .adc_enable(adc_enable), .special_trigger(special_trigger), .conv_start(conv_start),
   .unit_request_flag(unit_request_flag));

/* File: verif/ccp_pin_model.sv */
`timescale 1ns/10ps
module ccp_pin_model (
   input wire logic aclk,
   input wire logic pin_out,
   input wire logic pin_oe,
   output logic pin_in,
   output logic adc_enable
);
   logic pad_q = 1'b0;
   logic adc_q = 1'b0;
   // the detector sees the unit's own drive while it owns the pad
   assign pin_in = pin_oe ? pin_out : pad_q;
   assign adc_enable = adc_q;
   // random widths give both prompt and slow edges
   task automatic edges(input int n);
      repeat (n) begin
         repeat (3 + $urandom_range(5)) @(posedge aclk);
         pad_q <= 1'b1;
         repeat (3 + $urandom_range(5)) @(posedge aclk);
         pad_q <= 1'b0;
      end
      repeat (6) @(posedge aclk);
   endtask : edges
endmodule : ccp_pin_model

/* File: verif/capture_compare_pwm_unit_test.sv */
`timescale 1ns/10ps
`include "ccp_cfg.svh"
module capture_compare_pwm_unit_test;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid, pin_in, pin_out, pin_oe;
   logic adc_enable, special_trigger, conv_start, unit_request_flag;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, r, r2;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   int bad_count, cmp_count, c, d, p, k, h, t, n, m;
   int cap_q[$];
   ccp_unit dut_u (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
      .adc_enable(adc_enable), .special_trigger(special_trigger), .conv_start(conv_start),
      .unit_request_flag(unit_request_flag));
   ccp_pin_model pm_u (.aclk(aclk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in), .adc_enable(adc_enable));

   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", s, e, g);
      end
   endtask : chk

   // handshakes are judged at the falling edge, so sampling never races the flops
   task automatic wr(input logic [7:0] a, input int v, input logic [1:0] er = 2'h0);
      logic b, aw, w;
      b = 1'b0;
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (!b) begin
         @(negedge aclk);
         aw = awvalid & awready;
         w = wvalid & wready;
         b = bvalid & bready;
         if (b) chk("bresp", er, bresp);
         @(posedge aclk);
         if (aw) awvalid <= 1'b0;
         if (w) wvalid <= 1'b0;
         bready <= bvalid & !b;
      end
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] v, input logic [1:0] er = 2'h0);
      logic b, ar;
      b = 1'b0;
      araddr <= a;
      arvalid <= 1'b1;
      while (!b) begin
         @(negedge aclk);
         ar = arvalid & arready;
         b = rvalid & rready;
         v = rdata;
         if (b) chk("rresp", er, rresp);
         @(posedge aclk);
         if (ar) arvalid <= 1'b0;
         rready <= rvalid & !b;
      end
   endtask : rd

   // off first, so the capture prescaler starts from zero
   task automatic mode(input int v);
      wr(`CCP_OFF_CTRL, 0);
      wr(`CCP_OFF_CTRL, v);
      wr(`CCP_OFF_STATUS, 3);
   endtask : mode

   task automatic meas(output int h, output int t);
      realtime t0;
      repeat (2) @(posedge pin_out);
      t0 = $realtime;
      @(negedge pin_out);
      h = int'(($realtime - t0) / 10.0);
      @(posedge pin_out);
      t = int'(($realtime - t0) / 10.0);
   endtask : meas

   task automatic report_and_stop();
      if (bad_count == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : report_and_stop

   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   initial begin
      #600000;
      bad_count++;
      report_and_stop();
   end

   initial begin
      aresetn = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      awaddr = '0;
      araddr = '0;
      wdata = '0;
      wstrb = 4'hf;
      c = $urandom(17344);
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(`CCP_OFF_CTRL, r);
      chk("ctrl_rst", 0, r);
      chk("oe_rst", 0, pin_oe);
      rd(8'h28, r, `CCP_RESP_SLVERR);
      chk("unmapped", 0, r);
      wr(8'h2c, 1, `CCP_RESP_SLVERR);
      for (m = 4; m < 8; m++) begin
         n = m == 6 ? 4 : m == 7 ? 16 : 1;
         c = $urandom_range(16'hffff);
         wr(`CCP_OFF_T1_CNT, c);
         mode(m);
         pm_u.edges(n - 1);
         chk("early_flag", 0, unit_request_flag);
         pm_u.edges(1);
         chk("cap_flag", 1, unit_request_flag);
         cap_q.push_back(c);
         cap_q.push_back($urandom_range(16'hffff));
         wr(`CCP_OFF_T1_CNT, cap_q[$]);
         pm_u.edges(n);
         rd(`CCP_OFF_CAP_LO, r);
         rd(`CCP_OFF_CAP_HI, r2);
         chk("capture", cap_q[$], {r2[7:0], r[7:0]});
         wr(`CCP_OFF_STATUS, 1);
         chk("flag_clr", 0, unit_request_flag);
      end
      mode(`CCP_M_CAP_RISE);
      wr(`CCP_OFF_PIN, 0);
      wr(`CCP_OFF_STATUS, 1);
      wr(`CCP_OFF_PIN, 2);
      repeat (6) @(posedge aclk);
      chk("own_edge", 1, unit_request_flag);
      // set, toggle after a cleared latch, clear, then flag only over a high port
      for (m = 0; m < 4; m++) begin
         k = m == 0 ? 8 : m == 1 ? 2 : m == 2 ? 9 : 10;
         c = 1 + $urandom_range(16'hfffe);
         wr(`CCP_OFF_T1_CNT, 0);
         wr(`CCP_OFF_PIN, {k > 8, 1'b0});
         wr(`CCP_OFF_CAP_LO, c);
         wr(`CCP_OFF_CAP_HI, c >> 8);
         mode(k);
         wr(`CCP_OFF_T1_CNT, c);
         repeat (3) @(negedge aclk);
         chk("cmp_pin", k != 9, pin_out);
         chk("cmp_flag", 1, unit_request_flag);
         @(posedge aclk);
      end
      for (m = 0; m < 2; m++) begin
         pm_u.adc_q <= m[0];
         c = 80 + $urandom_range(1000);
         wr(`CCP_OFF_CAP_LO, c);
         wr(`CCP_OFF_CAP_HI, c >> 8);
         wr(`CCP_OFF_T1_CNT, c - 60);
         mode(`CCP_M_CMP_SPEC);
         wr(`CCP_OFF_T1_CTL, 1);
         n = 0;
         while (special_trigger !== 1'b1 && n < 300) begin
            @(negedge aclk);
            n++;
         end
         chk("trig", 1, special_trigger);
         chk("conv", m, conv_start);
         @(posedge aclk);
         rd(`CCP_OFF_T1_CNT, r);
         chk("t1_restart", 1, r < 20);
         rd(`CCP_OFF_STATUS, r);
         chk("no_t1_ovf", 0, r[1]);
      end
      for (m = 0; m < 3; m++) begin
         p = 1 + $urandom_range(6);
         d = 1 + $urandom_range(4 * p + 2);
         k = m == 2 ? 16 : m ? 4 : 1;
         wr(`CCP_OFF_PIN, 2);
         chk("oe_drive", 1, pin_oe);
         wr(`CCP_OFF_PERIOD, p);
         wr(`CCP_OFF_CAP_LO, d >> 2);
         mode(12 + m | (d & 3) << 4);
         wr(`CCP_OFF_T2_CTL, 1 | m << 1);
         meas(h, t);
         chk("pwm_high", d * k, h);
         chk("pwm_period", 4 * (p + 1) * k, t);
         rd(`CCP_OFF_CAP_HI, r);
         chk("duty_used", d >> 2, r);
         wr(`CCP_OFF_CAP_HI, 8'hff);
         rd(`CCP_OFF_CAP_HI, r);
         chk("duty_ro", d >> 2, r);
         wr(`CCP_OFF_CTRL, 0);
         n = 0;
         repeat (t + 4) begin
            @(negedge aclk);
            n += pin_out !== 1'b1;
         end
         chk("released", 0, n);
         @(posedge aclk);
      end
      report_and_stop();
   end
endmodule : capture_compare_pwm_unit_test
